// [shared/tls_pkg.sv]
// Purpose: Shared constants and types for the twilight lighting scheduler
// Assumes: Times of day in whole seconds since midnight (0..86399)
// Notes:   Register map sits on APB, one 32-bit word per register
package tls_pkg;

    localparam int unsigned TLS_TOD_W        = 17;
    localparam logic [16:0] TLS_SEC_PER_DAY  = 17'h15180;
    localparam logic [16:0] TLS_MIN_OFFSET   = 17'h00001;

    localparam logic [7:0]  TLS_ST_FORCE_HI  = 8'h65;
    localparam logic [7:0]  TLS_ST_FORCE_LO  = 8'h66;
    localparam logic [7:0]  TLS_ST_MANUAL    = 8'h67;
    localparam logic [7:0]  TLS_ST_DISABLED  = 8'h68;
    localparam logic [7:0]  TLS_ST_BUTTON    = 8'h6e;
    localparam logic [7:0]  TLS_ST_DAY_ON    = 8'h6f;
    localparam logic [7:0]  TLS_ST_DAY_OFF   = 8'h70;
    localparam logic [7:0]  TLS_ST_RISE_ON   = 8'h71;
    localparam logic [7:0]  TLS_ST_RISE_OFF  = 8'h72;
    localparam logic [7:0]  TLS_ST_SET_ON    = 8'h73;
    localparam logic [7:0]  TLS_ST_SET_OFF   = 8'h74;
    localparam logic [7:0]  TLS_ST_IDLE      = 8'h00;

    localparam logic [11:0] TLS_OFS_CTRL     = 12'h000;
    localparam logic [11:0] TLS_OFS_DAY_ON   = 12'h004;
    localparam logic [11:0] TLS_OFS_DAY_OFF  = 12'h008;
    localparam logic [11:0] TLS_OFS_RISE_LD  = 12'h00c;
    localparam logic [11:0] TLS_OFS_RISE_LG  = 12'h010;
    localparam logic [11:0] TLS_OFS_SET_LD   = 12'h014;
    localparam logic [11:0] TLS_OFS_SET_LG   = 12'h018;
    localparam logic [11:0] TLS_OFS_STATUS   = 12'h01c;

    localparam int unsigned TLS_CTRL_ENA     = 0;
    localparam int unsigned TLS_CTRL_FHI     = 1;
    localparam int unsigned TLS_CTRL_FLO     = 2;
    localparam int unsigned TLS_CTRL_MAN     = 3;
    localparam int unsigned TLS_CTRL_SAT     = 4;
    localparam int unsigned TLS_CTRL_SUN     = 5;
    localparam int unsigned TLS_CTRL_REST    = 6;
    localparam logic [6:0]  TLS_CTRL_RST     = 7'h01;

    localparam logic [2:0]  TLS_DOW_SAT      = 3'h6;
    localparam logic [2:0]  TLS_DOW_SUN      = 3'h7;

    typedef struct packed {
        logic [16:0] time_of_day;
        logic [2:0]  day_of_week;
        logic [16:0] sunrise_time;
        logic [16:0] sunset_time;
        logic        rest_day_flag;
    } tls_cal_t;

    typedef struct packed {
        logic [16:0] day_on_time;
        logic [16:0] day_off_time;
        logic [16:0] pre_sunrise_lead;
        logic [16:0] post_sunrise_lag;
        logic [16:0] pre_sunset_lead;
        logic [16:0] post_sunset_lag;
    } tls_times_t;

endpackage

// [rtl/tls_point_calc.sv]
// Purpose: Compute sun-relative switch points, wrapped around midnight
// Assumes: Inputs in seconds, below one day
// Notes:   Offsets under the minimum leave the point inactive
`timescale 1ns/1ns
module tls_point_calc
    import tls_pkg::*;
(
    input  wire logic [16:0] i_base,
    input  wire logic [16:0] i_offset,
    input  wire logic        i_subtract,
    output logic      [16:0] o_point,
    output logic             o_active
);
    wire logic [17:0] sum_w  = {1'b0, i_base} + {1'b0, i_offset};
    wire logic [17:0] diff_w = {1'b0, i_base} + {1'b0, TLS_SEC_PER_DAY} - {1'b0, i_offset};
    wire logic [17:0] raw_w  = i_subtract ? diff_w : sum_w;
    wire logic [17:0] day_w  = {1'b0, TLS_SEC_PER_DAY};

    assign o_point  = (raw_w >= day_w) ? 17'(raw_w - day_w) : raw_w[16:0];
    assign o_active = (i_offset >= TLS_MIN_OFFSET);
endmodule

// [rtl/tls_scheduler.sv]
// Purpose: Twilight lighting scheduler with APB register access
// Assumes: Calendar inputs come from another clock or pins, synchronised here
// Notes:   One evaluation per clock; status reports last cause
// Notes on behaviour
// - Enable is asserted unless driven low
// - Disabled: output low, status 104
// - Force high only: output high, 101
// - Force low only: output low, 102
// - Both forces: output copies manual, 103
// - Button toggles output, status 110
// - Day on/off times switch, 111/112
// - Sunrise lead/lag points switch, 113/114
// - Sunset lead/lag points switch, 115/116
// - Zero setting disables that switch point
// - Sun offsets act only from one second
// - Weekend and rest days suppress unless allowed
//
// Added by the designer: the address map and the APB interface to the registers.
`timescale 1ns/1ns
module tls_scheduler
    import tls_pkg::*;
(
    input  wire logic        i_clk_sys,
    input  wire logic        i_resetn,
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [11:0] i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic      [31:0] o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    input  wire logic        i_button,
    input  wire tls_cal_t    i_cal,
    output logic             o_switch,
    output logic      [7:0]  o_status
);
    logic [6:0]  ctrl_q;
    tls_times_t  times_q;
    tls_cal_t    cal_s1_q;
    tls_cal_t    cal_q;
    tls_cal_t    cal_p_q;
    logic        btn_s1_q;
    logic        btn_s2_q;
    logic        btn_prev_q;
    logic [16:0] tod_prev_q;
    logic        tod_valid_q;
    logic        sw_q;
    logic [7:0]  st_q;
    logic        sw_d;
    logic [7:0]  st_d;

    // Register access
    wire logic access_w = i_psel && i_penable;
    wire logic wr_w     = access_w && i_pwrite;
    wire logic hit_ctrl = (i_paddr == TLS_OFS_CTRL);
    wire logic hit_don  = (i_paddr == TLS_OFS_DAY_ON);
    wire logic hit_doff = (i_paddr == TLS_OFS_DAY_OFF);
    wire logic hit_rld  = (i_paddr == TLS_OFS_RISE_LD);
    wire logic hit_rlg  = (i_paddr == TLS_OFS_RISE_LG);
    wire logic hit_sld  = (i_paddr == TLS_OFS_SET_LD);
    wire logic hit_slg  = (i_paddr == TLS_OFS_SET_LG);
    wire logic hit_st   = (i_paddr == TLS_OFS_STATUS);
    wire logic mapped_w = hit_ctrl || hit_don || hit_doff || hit_rld || hit_rlg
                          || hit_sld || hit_slg || hit_st;
    logic [31:0] rdata_w;

    always_comb
    begin
        if (hit_ctrl)
            rdata_w = {25'h0000000, ctrl_q};
        else if (hit_don)
            rdata_w = {15'h0000, times_q.day_on_time};
        else if (hit_doff)
            rdata_w = {15'h0000, times_q.day_off_time};
        else if (hit_rld)
            rdata_w = {15'h0000, times_q.pre_sunrise_lead};
        else if (hit_rlg)
            rdata_w = {15'h0000, times_q.post_sunrise_lag};
        else if (hit_sld)
            rdata_w = {15'h0000, times_q.pre_sunset_lead};
        else if (hit_slg)
            rdata_w = {15'h0000, times_q.post_sunset_lag};
        else if (hit_st)
            rdata_w = {23'h000000, sw_q, st_q};
        else
            rdata_w = 32'h00000000;
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (!i_resetn)
        begin
            ctrl_q  <= TLS_CTRL_RST;
            times_q <= '0;
        end
        else if (wr_w)
        begin
            if (hit_ctrl)
                ctrl_q <= i_pwdata[6:0];
            else if (hit_don)
                times_q.day_on_time <= i_pwdata[16:0];
            else if (hit_doff)
                times_q.day_off_time <= i_pwdata[16:0];
            else if (hit_rld)
                times_q.pre_sunrise_lead <= i_pwdata[16:0];
            else if (hit_rlg)
                times_q.post_sunrise_lag <= i_pwdata[16:0];
            else if (hit_sld)
                times_q.pre_sunset_lead <= i_pwdata[16:0];
            else if (hit_slg)
                times_q.post_sunset_lag <= i_pwdata[16:0];
        end
    end

    // Zero-wait slave: pready registered, high in the access cycle
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_resetn)
        begin
            o_pready  <= 1'b0;
            o_pslverr <= 1'b0;
            o_prdata  <= 32'h00000000;
        end
        else
        begin
            o_pready  <= i_psel && !i_penable;
            o_pslverr <= i_psel && !i_penable && !mapped_w;
            o_prdata  <= rdata_w;
        end
    end

    // Input synchronisers
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_resetn)
        begin
            cal_s1_q   <= '0;
            cal_q      <= '0;
            cal_p_q    <= '0;
            btn_s1_q   <= 1'b0;
            btn_s2_q   <= 1'b0;
            btn_prev_q <= 1'b0;
        end
        else
        begin
            cal_s1_q   <= i_cal;
            cal_q      <= cal_s1_q;
            cal_p_q    <= cal_q;
            btn_s1_q   <= i_button;
            btn_s2_q   <= btn_s1_q;
            btn_prev_q <= btn_s2_q;
        end
    end

    // Switch points
    logic [16:0] rise_on_w;
    logic [16:0] rise_off_w;
    logic [16:0] set_on_w;
    logic [16:0] set_off_w;
    logic        rise_on_act;
    logic        rise_off_act;
    logic        set_on_act;
    logic        set_off_act;

    tls_point_calc u_rise_on  (.i_base(cal_p_q.sunrise_time), .i_offset(times_q.pre_sunrise_lead),
                               .i_subtract(1'b1), .o_point(rise_on_w),  .o_active(rise_on_act));
    tls_point_calc u_rise_off (.i_base(cal_p_q.sunrise_time), .i_offset(times_q.post_sunrise_lag),
                               .i_subtract(1'b0), .o_point(rise_off_w), .o_active(rise_off_act));
    tls_point_calc u_set_on   (.i_base(cal_p_q.sunset_time),  .i_offset(times_q.pre_sunset_lead),
                               .i_subtract(1'b1), .o_point(set_on_w),   .o_active(set_on_act));
    tls_point_calc u_set_off  (.i_base(cal_p_q.sunset_time),  .i_offset(times_q.post_sunset_lag),
                               .i_subtract(1'b0), .o_point(set_off_w),  .o_active(set_off_act));

    // Calendar word used only after two equal samples, so a torn update never matches
    wire logic        cal_ok  = (cal_q == cal_p_q);
    wire logic [16:0] tod_w   = cal_p_q.time_of_day;
    // A point acts only in the cycle the time of day first reaches it
    wire logic        new_tod = cal_ok && (!tod_valid_q || (tod_w != tod_prev_q));
    wire logic ena_w   = ctrl_q[TLS_CTRL_ENA];
    wire logic fhi_w   = ctrl_q[TLS_CTRL_FHI];
    wire logic flo_w   = ctrl_q[TLS_CTRL_FLO];
    wire logic man_w   = ctrl_q[TLS_CTRL_MAN];
    wire logic btn_rise = btn_s2_q && !btn_prev_q;
    wire logic blocked = ((cal_p_q.day_of_week == TLS_DOW_SAT) && !ctrl_q[TLS_CTRL_SAT])
                         || ((cal_p_q.day_of_week == TLS_DOW_SUN) && !ctrl_q[TLS_CTRL_SUN])
                         || (cal_p_q.rest_day_flag && !ctrl_q[TLS_CTRL_REST]);
    wire logic auto_ok = new_tod && !blocked;
    wire logic hit_day_on  = auto_ok && (times_q.day_on_time != '0) && (tod_w == times_q.day_on_time);
    wire logic hit_day_off = auto_ok && (times_q.day_off_time != '0) && (tod_w == times_q.day_off_time);
    wire logic hit_r_on    = auto_ok && rise_on_act && (tod_w == rise_on_w);
    wire logic hit_r_off   = auto_ok && rise_off_act && (tod_w == rise_off_w);
    wire logic hit_s_on    = auto_ok && set_on_act && (tod_w == set_on_w);
    wire logic hit_s_off   = auto_ok && set_off_act && (tod_w == set_off_w);

    always_comb
    begin
        sw_d = sw_q;
        st_d = st_q;
        if (!ena_w)
        begin
            sw_d = 1'b0;
            st_d = TLS_ST_DISABLED;
        end
        else if (fhi_w && !flo_w)
        begin
            sw_d = 1'b1;
            st_d = TLS_ST_FORCE_HI;
        end
        else if (flo_w && !fhi_w)
        begin
            sw_d = 1'b0;
            st_d = TLS_ST_FORCE_LO;
        end
        else if (fhi_w && flo_w)
        begin
            sw_d = man_w;
            st_d = TLS_ST_MANUAL;
        end
        else if (btn_rise)
        begin
            sw_d = !sw_q;
            st_d = TLS_ST_BUTTON;
        end
        else if (hit_day_on)
        begin
            sw_d = 1'b1;
            st_d = TLS_ST_DAY_ON;
        end
        else if (hit_day_off)
        begin
            sw_d = 1'b0;
            st_d = TLS_ST_DAY_OFF;
        end
        else if (hit_r_on)
        begin
            sw_d = 1'b1;
            st_d = TLS_ST_RISE_ON;
        end
        else if (hit_r_off)
        begin
            sw_d = 1'b0;
            st_d = TLS_ST_RISE_OFF;
        end
        else if (hit_s_on)
        begin
            sw_d = 1'b1;
            st_d = TLS_ST_SET_ON;
        end
        else if (hit_s_off)
        begin
            sw_d = 1'b0;
            st_d = TLS_ST_SET_OFF;
        end
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (!i_resetn)
        begin
            sw_q        <= 1'b0;
            st_q        <= TLS_ST_IDLE;
            tod_prev_q  <= '0;
            tod_valid_q <= 1'b0;
            o_switch    <= 1'b0;
            o_status    <= TLS_ST_IDLE;
        end
        else
        begin
            sw_q        <= sw_d;
            st_q        <= st_d;
            tod_prev_q  <= cal_ok ? tod_w : tod_prev_q;
            tod_valid_q <= tod_valid_q || cal_ok;
            o_switch    <= sw_d;
            o_status    <= st_d;
        end
    end

    AST_DISABLE_LOW: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        !ena_w |=> (!o_switch && o_status == TLS_ST_DISABLED))
        else $error("disabled block drives output");
    AST_FORCE_HIGH: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        (ena_w && fhi_w && !flo_w) |=> (o_switch && o_status == TLS_ST_FORCE_HI))
        else $error("force high not applied");
    AST_FORCE_LOW: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        (ena_w && flo_w && !fhi_w) |=> (!o_switch && o_status == TLS_ST_FORCE_LO))
        else $error("force low not applied");
    AST_MANUAL_COPY: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        (ena_w && flo_w && fhi_w) |=> (o_switch == $past(man_w) && o_status == TLS_ST_MANUAL))
        else $error("manual level not copied");
    AST_BUTTON_TOGGLE: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        (ena_w && !fhi_w && !flo_w && btn_rise) |=> (o_switch != $past(o_switch) && o_status == TLS_ST_BUTTON))
        else $error("button did not toggle");
    AST_DAY_ON: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        (ena_w && !fhi_w && !flo_w && !btn_rise && hit_day_on) |=> (o_switch && o_status == TLS_ST_DAY_ON))
        else $error("day on point missed");
    AST_ZERO_INACTIVE: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        (ena_w && !fhi_w && !flo_w && !btn_rise && (times_q.day_on_time == '0) && !hit_day_off
         && !hit_r_on && !hit_r_off && !hit_s_on && !hit_s_off) |=> $stable(o_switch))
        else $error("zero day time acted");
    AST_BLOCKED_DAY: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        blocked |-> !(hit_day_on || hit_day_off || hit_r_on || hit_r_off || hit_s_on || hit_s_off))
        else $error("switch on suppressed day");
    AST_HOLD: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        (ena_w && !fhi_w && !flo_w && !btn_rise && !new_tod) |=> $stable(o_switch))
        else $error("output moved between points");
    AST_BTN_ONCE: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        (ena_w && !fhi_w && !flo_w && btn_s2_q && btn_prev_q && !new_tod) |=> $stable(o_switch))
        else $error("button edge repeated");
    AST_SUN_MIN: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        (times_q.pre_sunset_lead < TLS_MIN_OFFSET) |-> !hit_s_on)
        else $error("short offset acted");

    CV_BUTTON: cover property (@(posedge i_clk_sys) disable iff (!i_resetn) o_status == TLS_ST_BUTTON);
    CV_SET_ON: cover property (@(posedge i_clk_sys) disable iff (!i_resetn) o_status == TLS_ST_SET_ON);
    CV_RISE_OFF: cover property (@(posedge i_clk_sys) disable iff (!i_resetn) o_status == TLS_ST_RISE_OFF);
    CV_BLOCKED: cover property (@(posedge i_clk_sys) disable iff (!i_resetn) blocked && new_tod);
endmodule

// [bench/tls_cal_model.sv]
// Purpose: Calendar, sun-time and holiday source for the scheduler
// Assumes: Values change only just after a rising clock edge
// Notes:   Sunrise 1000 s, sunset 5000 s; holiday flag moves with the day only
`timescale 1ns/1ns
module tls_cal_model
    import tls_pkg::*;
(
    input  wire logic i_clk_sys,
    output tls_cal_t  o_cal
);
    logic [16:0] tod_q = 17'h00032;
    logic [2:0]  dow_q = 3'h3;
    logic        hol_q = 1'b0;

    // Flag belongs to the whole day, never toggled within it
    assign o_cal = '{tod_q, dow_q, 17'h003e8, 17'h01388, hol_q};

    task automatic set_tod(input logic [16:0] t);
        @(posedge i_clk_sys);
        tod_q <= t;
    endtask

    task automatic set_day(input logic [2:0] d, input logic h);
        @(posedge i_clk_sys);
        dow_q <= d;
        hol_q <= h;
    endtask
endmodule

// [bench/tls_scheduler_bench.sv]
// Purpose: Self-checking bench for the twilight lighting scheduler
// Assumes: Zero-wait APB slave, four-edge calendar-to-output latency
// Notes:   Outputs are read at the edge, before that edge's updates land
`timescale 1ns/1ns
module tls_scheduler_bench
    import tls_pkg::*;
;
    logic        clk;
    logic        resetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        button;
    tls_cal_t    cal;
    logic        sw;
    logic [7:0]  st;
    logic [31:0] rdv;
    logic        erv;
    int          error_cnt = 0;
    int          total_checks = 0;
    logic [16:0] tims [6] = '{17'h00064, 17'h000c8, 17'h0000a, 17'h00014, 17'h0001e, 17'h00028};
    logic [16:0] tods [6] = '{17'h00064, 17'h000c8, 17'h003de, 17'h003fc, 17'h0136a, 17'h013b0};
    logic [7:0]  sts [6]  = '{TLS_ST_DAY_ON, TLS_ST_DAY_OFF, TLS_ST_RISE_ON, TLS_ST_RISE_OFF,
                              TLS_ST_SET_ON, TLS_ST_SET_OFF};
    logic [6:0]  ctl [6]  = '{7'h00, 7'h0e, 7'h03, 7'h05, 7'h07, 7'h0f};
    logic [7:0]  fst [6]  = '{TLS_ST_DISABLED, TLS_ST_DISABLED, TLS_ST_FORCE_HI, TLS_ST_FORCE_LO,
                              TLS_ST_MANUAL, TLS_ST_MANUAL};
    logic [5:0]  fsw      = 6'b100100;

    tls_cal_model cal_u (.i_clk_sys(clk), .o_cal(cal));

    tls_scheduler dut_u (
        .i_clk_sys(clk), .i_resetn(resetn), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
        .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_button(button), .i_cal(cal), .o_switch(sw), .o_status(st)
    );

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk_out(input string n, input logic esw, input logic [7:0] est);
        total_checks++;
        if ({sw, st} !== {esw, est})
        begin
            error_cnt++;
            $display("ERROR %s expected %h/%h seen %h/%h", n, esw, est, sw, st);
        end
    endtask

    task automatic chk_word(input string n, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e)
        begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask

    // One APB transfer; request held until pready is seen at an edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        rdv = prdata;
        erv = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        chk_word("pready", 32'h1, {31'h0, pready});
    endtask

    task automatic tod_chk(input logic [16:0] t, input logic esw, input logic [7:0] est);
        cal_u.set_tod(t);
        repeat (5) @(posedge clk);
        chk_out("switch/status", esw, est);
    endtask

    task automatic press();
        @(posedge clk);
        button <= 1'b1;
        repeat (10) @(posedge clk);
        button <= 1'b0;
        repeat (4) @(posedge clk);
    endtask

    initial
    begin
        resetn  = 1'b0;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 12'h000;
        pwdata  = 32'h0;
        button  = 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        chk_out("reset", 1'b0, TLS_ST_IDLE);
        apb(1'b0, TLS_OFS_CTRL, 32'h0);
        chk_word("ctrl", 32'h00000001, rdv);
        chk_word("pslverr", 32'h0, {31'h0, erv});
        apb(1'b1, 12'h040, 32'h0);
        chk_word("pslverr", 32'h1, {31'h0, erv});
        apb(1'b0, TLS_OFS_CTRL, 32'h0);
        chk_word("ctrl", 32'h00000001, rdv);
        for (int i = 0; i < 6; i++)
            apb(1'b1, TLS_OFS_DAY_ON + 12'(4 * i), {15'h0, tims[i]});
        apb(1'b0, TLS_OFS_SET_LG, 32'h0);
        chk_word("set lag", 32'h00000028, rdv);
        for (int i = 0; i < 6; i++)
        begin
            tod_chk(tods[i], ~i[0], sts[i]);
            tod_chk(tods[i] + 17'h00002, ~i[0], sts[i]);
        end
        apb(1'b1, TLS_OFS_SET_LD, 32'h0);
        tod_chk(17'h01388, 1'b0, TLS_ST_SET_OFF);
        apb(1'b1, TLS_OFS_DAY_ON, 32'h0);
        tod_chk(17'h00000, 1'b0, TLS_ST_SET_OFF);
        apb(1'b1, TLS_OFS_SET_LD, 32'h1);
        tod_chk(17'h01387, 1'b1, TLS_ST_SET_ON);
        apb(1'b1, TLS_OFS_DAY_ON, 32'h64);
        press();
        chk_out("button", 1'b0, TLS_ST_BUTTON);
        press();
        chk_out("button", 1'b1, TLS_ST_BUTTON);
        cal_u.set_day(TLS_DOW_SAT, 1'b0);
        tod_chk(17'h000c8, 1'b1, TLS_ST_BUTTON);
        apb(1'b1, TLS_OFS_CTRL, 32'h11);
        tod_chk(17'h000c9, 1'b1, TLS_ST_BUTTON);
        tod_chk(17'h000c8, 1'b0, TLS_ST_DAY_OFF);
        cal_u.set_day(TLS_DOW_SUN, 1'b0);
        tod_chk(17'h00064, 1'b0, TLS_ST_DAY_OFF);
        apb(1'b1, TLS_OFS_CTRL, 32'h21);
        tod_chk(17'h00065, 1'b0, TLS_ST_DAY_OFF);
        tod_chk(17'h00064, 1'b1, TLS_ST_DAY_ON);
        cal_u.set_day(3'h3, 1'b1);
        tod_chk(17'h000c8, 1'b1, TLS_ST_DAY_ON);
        apb(1'b1, TLS_OFS_CTRL, 32'h41);
        tod_chk(17'h000c9, 1'b1, TLS_ST_DAY_ON);
        tod_chk(17'h000c8, 1'b0, TLS_ST_DAY_OFF);
        for (int i = 0; i < 6; i++)
        begin
            apb(1'b1, TLS_OFS_CTRL, {25'h0, ctl[i]});
            repeat (2) @(posedge clk);
            chk_out("override", fsw[i], fst[i]);
        end
        press();
        chk_out("override", 1'b1, TLS_ST_MANUAL);
        apb(1'b0, TLS_OFS_STATUS, 32'h0);
        chk_word("status reg", 32'h00000167, rdv);
        tally_and_finish();
    end

    initial
    begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        tally_and_finish();
    end
endmodule
